// ### hdl/hub_strap_pkg.sv
/*
 * Constants for the hub reset and strap-sampling block: register map,
 * field positions, reset values, timing counts and encodings.
 * Assumes a 125 MHz system clock and an Avalon-MM register bus.
 */
// Overview of operation
// - core power loss resets; release after 2.7 us
// - external vbus reset input forces reset
// - sample mode pin within 20 us
// - mode pin becomes output 50-60 ms after reset
// - output pin shows global suspend only
// - mode pin low individual, high gang
// - polarity strap 1 active-high, 0 active-low
// - port count straps 11/10/01/00 give 1-4
// - nonremovable_port_strap strap high marks port non-removable
// - clock straps select 48, 27, 12 MHz
// - gang mode honours port 1 overcurrent only
package hub_strap_pkg;
    localparam int CLK_MHZ = 125;
    localparam int REL_DELAY_NS = 2700;
    localparam int REL_CYC = (REL_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int SAMPLE_LIMIT_NS = 20000;
    localparam int SAMPLE_CYC = SAMPLE_LIMIT_NS * CLK_MHZ / 1000;
    localparam int OUT_MODE_MS = 50;
    localparam int OUT_MODE_CYC = OUT_MODE_MS * CLK_MHZ * 1000;
    localparam int CNT_W = 23;

    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CLEAR = 8'h04;
    localparam logic [7:0] ADDR_ENABLE = 8'h08;
    localparam logic [7:0] ADDR_CONFIG = 8'h0c;
    localparam logic [7:0] ADDR_CONTROL = 8'h10;
    localparam logic [7:0] ADDR_STATE = 8'h14;

    // status, clear and enable bit positions
    localparam int EV_LATCHED = 0;
    localparam int EV_OUT_MODE = 1;
    localparam int EV_SUSPEND = 2;
    localparam int EV_HUB_RESET = 3;
    localparam int EV_OC_LSB = 4;
    localparam int EV_W = 8;

    // config register fields
    localparam int CF_GANG = 0;
    localparam int CF_POL = 1;
    localparam int CF_PCODE_LSB = 2;
    localparam int CF_NONREM_LSB = 4;
    localparam int CF_CLK_LSB = 8;
    localparam int CF_NPORT_LSB = 12;

    // state register fields
    localparam int ST_PHASE_LSB = 0;
    localparam int ST_OC_LSB = 4;

    localparam int NPORT = 4;
    localparam logic [3:0] CONTROL_RST = 4'h0;
    localparam logic [EV_W-1:0] ENABLE_RST = 8'h00;

    // synchroniser lane layout and reset image
    localparam int SY_PGOOD = 0;
    localparam int SY_EXT_N = 1;
    localparam int SY_MODE = 2;
    localparam int SY_POL = 3;
    localparam int SY_PC_LO = 4;
    localparam int SY_PC_HI = 5;
    localparam int SY_NONREM = 6;
    localparam int SY_CLK_A = 10;
    localparam int SY_CLK_B = 11;
    localparam int SY_OC = 12;
    localparam int SY_W = 16;
    localparam logic [SY_W-1:0] SY_RST = 16'hf000;

    typedef enum logic [1:0] {
        CLK_SRC_48 = 2'b00,
        CLK_SRC_27 = 2'b01,
        CLK_SRC_12 = 2'b10
    } clk_src_t;

    typedef enum logic [1:0] {
        PH_RESET = 2'b00,
        PH_SAMPLE = 2'b01,
        PH_WAIT = 2'b10,
        PH_OUTPUT = 2'b11
    } phase_t;
endpackage : hub_strap_pkg

// ### hdl/hub_strap_reset_config.sv
/*
 * Hub reset sequencing and strap capture: combines core power-good and the
 * vbus-following reset pin, latches the board straps once after release,
 * turns the shared mode pin into a suspend output, and exposes state over
 * Avalon-MM with one level interrupt.
 * Assumes all pin inputs are asynchronous and global_suspend comes from
 * logic on sys_clk.
 */
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module hub_strap_reset_config
    import hub_strap_pkg::*;
#(
    parameter int REL_CYCLES = REL_CYC,
    parameter int OUT_CYCLES = OUT_MODE_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic core_power_good,
    input wire logic ext_reset_n,
    input wire logic mode_pin_i,
    output logic mode_pin_o,
    output logic mode_pin_oe,
    input wire logic switch_enable_polarity_strap,
    input wire logic port_count_strap_lo,
    input wire logic port_count_strap_hi,
    input wire logic [3:0] nonremovable_port_strap,
    input wire logic clk_sel_a,
    input wire logic clk_sel_b,
    input wire logic [3:0] overcurrent_in_n,
    input wire logic global_suspend,
    output logic hub_reset,
    output logic [3:0] port_enable,
    output logic [3:0] port_nonremovable,
    output logic [1:0] ref_clk_src,
    output logic gang_mode,
    output logic [3:0] power_switch_en,
    output logic [3:0] port_overcurrent,
    output logic irq
);
    import hub_strap_pkg::*;

    // elaboration-time range checks on the timing parameters
    if (REL_CYCLES < 1 || REL_CYCLES >= SAMPLE_CYC) begin : g_bad_rel
        $error("REL_CYCLES out of range");
    end
    if (OUT_CYCLES < 1 || OUT_CYCLES >= (1 << CNT_W)) begin : g_bad_out
        $error("OUT_CYCLES does not fit the counter");
    end

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        phase_t phase;
        logic [CNT_W-1:0] cnt;
        logic gang;
        logic pol;
        logic [1:0] pcode;
        logic [3:0] ports;
        logic [3:0] nonrem;
        clk_src_t clk_src;
        logic [3:0] control;
        logic [EV_W-1:0] status;
        logic [EV_W-1:0] enable;
        logic [3:0] oc;
        logic susp;
        logic waitreq;
        logic [31:0] rdata;
        logic irq;
        logic mode_o;
        logic mode_oe;
        logic [3:0] sw_en;
        logic hrst;
    } state_t;

    localparam state_t STATE_RST = '{
        phase: PH_RESET, cnt: '0, gang: 1'b0, pol: 1'b1, pcode: 2'b00,
        ports: 4'h0, nonrem: 4'h0, clk_src: CLK_SRC_12, control: CONTROL_RST,
        status: '0, enable: ENABLE_RST, oc: 4'h0, susp: 1'b0, waitreq: 1'b1,
        rdata: 32'h0000_0000, irq: 1'b0, mode_o: 1'b0, mode_oe: 1'b0,
        sw_en: 4'h0, hrst: 1'b1
    };

    state_t s_q;
    state_t s_d;
    logic [SY_W-1:0] sy;

    pin_sync #(
        .W(SY_W),
        .RST_VAL(SY_RST)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .d({overcurrent_in_n, clk_sel_b, clk_sel_a, nonremovable_port_strap,
            port_count_strap_hi, port_count_strap_lo,
            switch_enable_polarity_strap, mode_pin_i, ext_reset_n,
            core_power_good}),
        .q(sy)
    );

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic [3:0] port_mask(input logic [1:0] code);
        case (code)
            2'b11: port_mask = 4'h1;
            2'b10: port_mask = 4'h3;
            2'b01: port_mask = 4'h7;
            default: port_mask = 4'hf;
        endcase
    endfunction : port_mask

    function automatic clk_src_t clk_decode(input logic a, input logic b);
        case ({a, b})
            2'b01: clk_decode = CLK_SRC_48;
            2'b10: clk_decode = CLK_SRC_27;
            2'b11: clk_decode = CLK_SRC_12;
            default: clk_decode = CLK_SRC_12;
        endcase
    endfunction : clk_decode

    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        be_merge = r;
    endfunction : be_merge

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic power_fail;
        logic [3:0] oc_now;
        logic [EV_W-1:0] ev;
        logic [EV_W-1:0] clr;
        logic [31:0] wr;
        logic wr_go;
        power_fail = 1'b0;
        oc_now = 4'h0;
        ev = '0;
        clr = '0;
        wr = 32'h0000_0000;
        wr_go = 1'b0;
        s_d = s_q;

        // power and reset sequencing
        power_fail = !sy[SY_PGOOD] || !sy[SY_EXT_N];
        if (power_fail) begin
            if (s_q.phase != PH_RESET) begin
                ev[EV_HUB_RESET] = 1'b1;
            end
            s_d.phase = PH_RESET;
            s_d.cnt = '0;
        end else begin
            case (s_q.phase)
                PH_RESET: begin
                    if (s_q.cnt >= CNT_W'(REL_CYCLES - 1)) begin
                        s_d.phase = PH_SAMPLE;
                        s_d.cnt = '0;
                    end else begin
                        s_d.cnt = s_q.cnt + 1'b1;
                    end
                end
                PH_SAMPLE: begin
                    // one capture, well inside the decision window
                    s_d.gang = sy[SY_MODE];
                    s_d.pol = sy[SY_POL];
                    s_d.pcode = {sy[SY_PC_HI], sy[SY_PC_LO]};
                    s_d.ports = port_mask({sy[SY_PC_HI], sy[SY_PC_LO]});
                    s_d.nonrem = sy[SY_NONREM +: 4];
                    s_d.clk_src = clk_decode(sy[SY_CLK_A], sy[SY_CLK_B]);
                    ev[EV_LATCHED] = 1'b1;
                    // output-mode delay counts from the strap capture
                    s_d.phase = PH_WAIT;
                    s_d.cnt = '0;
                end
                PH_WAIT: begin
                    if (s_q.cnt >= CNT_W'(OUT_CYCLES - 1)) begin
                        s_d.phase = PH_OUTPUT;
                        ev[EV_OUT_MODE] = 1'b1;
                    end else begin
                        s_d.cnt = s_q.cnt + 1'b1;
                    end
                end
                PH_OUTPUT: begin
                    s_d.cnt = s_q.cnt;
                end
                default: begin
                    s_d.phase = PH_RESET;
                    s_d.cnt = '0;
                end
            endcase
        end

        // shared pin: input until output mode, then suspend flag
        s_d.hrst = (s_d.phase == PH_RESET);
        s_d.mode_oe = (s_d.phase == PH_OUTPUT);
        s_d.susp = (s_d.phase == PH_OUTPUT) && global_suspend;
        s_d.mode_o = s_d.susp;
        if (s_d.susp && !s_q.susp) begin
            ev[EV_SUSPEND] = 1'b1;
        end

        // overcurrent, gang mode keeps only port 1
        if (s_q.phase != PH_RESET && s_q.phase != PH_SAMPLE) begin
            oc_now = ~sy[SY_OC +: 4] & s_q.ports;
            if (s_q.gang) begin
                oc_now = {3'b000, oc_now[0]};
            end
        end
        s_d.oc = oc_now;
        ev[EV_OC_LSB +: 4] = oc_now & ~s_q.oc;

        // power switch enables, polarity from the strap
        for (int i = 0; i < NPORT; i++) begin
            logic on;
            on = s_q.control[i] && s_q.ports[i] && !oc_now[s_q.gang ? 0 : i] &&
                 (s_q.phase == PH_WAIT || s_q.phase == PH_OUTPUT);
            s_d.sw_en[i] = s_q.pol ? on : !on;
        end

        // avalon slave: one wait cycle, then release
        if (s_q.waitreq && (avs_read || avs_write)) begin
            s_d.waitreq = 1'b0;
            case (avs_address)
                ADDR_STATUS: s_d.rdata = {24'h00_0000, s_q.status};
                ADDR_ENABLE: s_d.rdata = {24'h00_0000, s_q.enable};
                ADDR_CONFIG: begin
                    s_d.rdata = 32'h0000_0000;
                    s_d.rdata[CF_GANG] = s_q.gang;
                    s_d.rdata[CF_POL] = s_q.pol;
                    s_d.rdata[CF_PCODE_LSB +: 2] = s_q.pcode;
                    s_d.rdata[CF_NONREM_LSB +: 4] = s_q.nonrem;
                    s_d.rdata[CF_CLK_LSB +: 2] = s_q.clk_src;
                    s_d.rdata[CF_NPORT_LSB +: 3] = 3'(s_q.ports[0]) + 3'(s_q.ports[1]) +
                                                   3'(s_q.ports[2]) + 3'(s_q.ports[3]);
                end
                ADDR_CONTROL: s_d.rdata = {28'h000_0000, s_q.control};
                ADDR_STATE: begin
                    s_d.rdata = 32'h0000_0000;
                    s_d.rdata[ST_PHASE_LSB +: 2] = s_q.phase;
                    s_d.rdata[ST_OC_LSB +: 4] = s_q.oc;
                end
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end else begin
            s_d.waitreq = 1'b1;
            wr_go = avs_write && !s_q.waitreq;
        end

        if (wr_go) begin
            case (avs_address)
                ADDR_CLEAR: begin
                    wr = be_merge(32'h0000_0000, avs_writedata, avs_byteenable);
                    clr = wr[EV_W-1:0];
                end
                ADDR_ENABLE: begin
                    wr = be_merge({24'h00_0000, s_q.enable}, avs_writedata, avs_byteenable);
                    s_d.enable = wr[EV_W-1:0];
                end
                ADDR_CONTROL: begin
                    wr = be_merge({28'h000_0000, s_q.control}, avs_writedata, avs_byteenable);
                    s_d.control = wr[3:0];
                end
                default: s_d.control = s_d.control;
            endcase
        end

        // sticky status: a new event beats a clear in the same cycle
        s_d.status = (s_q.status & ~clr) | ev;
        s_d.irq = |(s_d.status & s_d.enable);
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all from flops

    assign avs_readdata = s_q.rdata;
    assign avs_waitrequest = s_q.waitreq;
    assign mode_pin_o = s_q.mode_o;
    assign mode_pin_oe = s_q.mode_oe;
    assign hub_reset = s_q.hrst;
    assign port_enable = s_q.ports;
    assign port_nonremovable = s_q.nonrem;
    assign ref_clk_src = s_q.clk_src;
    assign gang_mode = s_q.gang;
    assign power_switch_en = s_q.sw_en;
    assign port_overcurrent = s_q.oc;
    assign irq = s_q.irq;
endmodule : hub_strap_reset_config
`default_nettype wire

// ### hdl/pin_sync.sv
/*
 * Two-stage synchroniser for a bus of asynchronous pin inputs.
 * Assumes each lane is an independent level; no lane is sampled coherently.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : pin_sync
`default_nettype wire

// ### tb/board_strap_model.sv
/* board straps, pull resistors and the vbus-following reset circuit
   the bench sets the strap image and requests plug events */
`timescale 1ns/1ps
`default_nettype none
module board_strap_model #(
    parameter int HOLD = 40
) (
    input wire logic sys_clk,
    input wire logic power_on,
    input wire logic plug_evt,
    input wire logic [9:0] strap_cfg,
    input wire logic mode_pin_o,
    input wire logic mode_pin_oe,
    output logic core_power_good,
    output logic ext_reset_n,
    output logic mode_pin_i,
    output logic switch_enable_polarity_strap,
    output logic port_count_strap_lo,
    output logic port_count_strap_hi,
    output logic [3:0] nonremovable_port_strap,
    output logic clk_sel_a,
    output logic clk_sel_b
);
    // stretch each plug well past the internal release
    int hold_q = 0;
    always @(posedge sys_clk) begin
        hold_q <= plug_evt ? HOLD : (hold_q > 0 ? hold_q - 1 : 0);
    end
    assign ext_reset_n = (hold_q == 0);
    assign core_power_good = power_on;
    // pull resistor sets the shared pin unless the hub drives it
    assign mode_pin_i = mode_pin_oe ? mode_pin_o : strap_cfg[0];
    assign {clk_sel_b, clk_sel_a, nonremovable_port_strap, port_count_strap_hi, port_count_strap_lo,
        switch_enable_polarity_strap} = strap_cfg[9:1];
endmodule : board_strap_model
`default_nettype wire

// ### tb/hub_strap_monitor.sv
/* port assertions for the hub strap block
   bound onto the top module from the bench */
`timescale 1ns/1ps
`default_nettype none
module hub_strap_monitor #(
    parameter int REL_CYCLES = 20,
    parameter int OUT_CYCLES = 1000
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic core_power_good,
    input wire logic ext_reset_n,
    input wire logic mode_pin_o,
    input wire logic mode_pin_oe,
    input wire logic global_suspend,
    input wire logic hub_reset,
    input wire logic gang_mode,
    input wire logic [3:0] port_enable,
    input wire logic [3:0] port_overcurrent,
    input wire logic [1:0] ref_clk_src
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    // cycles both supply pins have stayed high
    int up_q;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            up_q <= 0;
        end else begin
            up_q <= (core_power_good && ext_reset_n) ? up_q + 1 : 0;
        end
    end
    a_rel_delay: assert property ($fell(hub_reset) |-> up_q >= REL_CYCLES)
        else $error("reset released early");
    a_ext_reset: assert property ($fell(ext_reset_n) |-> ##[1:5] hub_reset)
        else $error("no reset on vbus event");
    a_sample_time: assert property (up_q == 2500 |-> !hub_reset)
        else $error("straps not taken in time");
    a_oe_window: assert property ($rose(mode_pin_oe) |-> up_q >= REL_CYCLES + OUT_CYCLES
        && up_q <= REL_CYCLES + OUT_CYCLES * 6 / 5) else $error("pin output out of window");
    a_suspend_flag: assert property (mode_pin_o |-> $past(global_suspend))
        else $error("suspend flag without suspend");
    a_port_code: assert property (!hub_reset && $past(!hub_reset, 2)
        |-> port_enable inside {4'h1, 4'h3, 4'h7, 4'hf}) else $error("bad port mask");
    a_clk_code: assert property (!hub_reset |-> ref_clk_src != 2'b11)
        else $error("bad clock source");
    a_gang_oc: assert property (gang_mode && !hub_reset |-> port_overcurrent[3:1] == 3'h0)
        else $error("overcurrent 2-4 seen in gang mode");
    a_strap_hold: assert property (!hub_reset && $past(!hub_reset) && $past(!hub_reset, 2)
        |-> $stable(gang_mode) && $stable(port_enable) && $stable(ref_clk_src))
        else $error("straps changed after latch");
    a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("late bus answer");
    a_bus_gap: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer longer than one cycle");
    c_oe: cover property ($rose(mode_pin_oe));
    c_release: cover property ($fell(hub_reset));
    c_flag: cover property (mode_pin_o);
endmodule : hub_strap_monitor
`default_nettype wire

// ### tb/hub_strap_reset_config_tb.sv
/* self-checking bench for the hub strap block
   straps come from the board model, registers over Avalon-MM */
`timescale 1ns/1ps
`default_nettype none
module hub_strap_reset_config_tb;
    import hub_strap_pkg::*;
    localparam int REL = 20;
    localparam int OUTC = 1000;
    localparam logic [9:0] CFG [4] = '{10'h21d, 10'h1aa, 10'h357, 10'h0e0};
    localparam logic [3:0] PE [4] = '{4'h1, 4'h3, 4'h7, 4'hf};
    localparam logic [1:0] CK [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] avs_address = 8'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [3:0] overcurrent_in_n = 4'hf;
    logic global_suspend = 1'b0;
    logic power_on = 1'b0;
    logic plug_evt = 1'b0;
    logic [9:0] strap_cfg = 10'h0;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, core_power_good, ext_reset_n, mode_pin_i, mode_pin_o, mode_pin_oe;
    logic switch_enable_polarity_strap, port_count_strap_lo, port_count_strap_hi, clk_sel_a, clk_sel_b;
    logic hub_reset, gang_mode, irq;
    logic [3:0] nonremovable_port_strap, port_enable, port_nonremovable, power_switch_en;
    logic [3:0] port_overcurrent, oc, pse;
    logic [1:0] ref_clk_src;
    logic [9:0] c;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;
    always #4 sys_clk = ~sys_clk;
    hub_strap_reset_config #(.REL_CYCLES(REL), .OUT_CYCLES(OUTC)) dut (
        .sys_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .core_power_good, .ext_reset_n, .mode_pin_i, .mode_pin_o,
        .mode_pin_oe, .switch_enable_polarity_strap, .port_count_strap_lo, .port_count_strap_hi,
        .nonremovable_port_strap, .clk_sel_a, .clk_sel_b, .overcurrent_in_n, .global_suspend,
        .hub_reset, .port_enable, .port_nonremovable, .ref_clk_src, .gang_mode, .power_switch_en,
        .port_overcurrent, .irq
    );
    board_strap_model #(.HOLD(40)) partner (
        .sys_clk, .power_on, .plug_evt, .strap_cfg, .mode_pin_o, .mode_pin_oe, .core_power_good,
        .ext_reset_n, .mode_pin_i, .switch_enable_polarity_strap, .port_count_strap_lo,
        .port_count_strap_hi, .nonremovable_port_strap, .clk_sel_a, .clk_sel_b
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge sys_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        check(k < 50, 1'b1);
    endtask : bus
    task automatic wait_rst(input logic v);
        int k;
        k = 0;
        while (hub_reset !== v && k < 300) begin
            @(negedge sys_clk);
            k++;
        end
        check(k < 300, 1'b1);
    endtask : wait_rst
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        power_on <= 1'b1;
        bus(1'b0, ADDR_ENABLE, 32'h0);
        check(rd, {24'h0, ENABLE_RST});
        bus(1'b0, ADDR_CONTROL, 32'h0);
        check(rd, {28'h0, CONTROL_RST});
        for (int i = 0; i < 4; i++) begin
            c = CFG[i];
            strap_cfg <= c;
            if (i == 1) power_on <= 1'b0;
            else plug_evt <= 1'b1;
            repeat (2) @(posedge sys_clk);
            power_on <= 1'b1;
            plug_evt <= 1'b0;
            wait_rst(1'b1);
            wait_rst(1'b0);
            repeat (3) @(negedge sys_clk);
            check(gang_mode, c[0]);
            check(port_enable, PE[i]);
            check(port_nonremovable, c[7:4]);
            check(ref_clk_src, CK[i]);
            bus(1'b0, ADDR_CONFIG, 32'h0);
            check(rd, {17'h0, 3'(i + 1), 2'h0, CK[i], c[7:0]});
            bus(1'b1, ADDR_CONTROL, 32'hf);
            overcurrent_in_n <= 4'hd;
            oc = c[0] ? 4'h0 : 4'h2 & PE[i];
            pse = PE[i] & ~oc;
            pse = c[1] ? pse : ~pse;
            repeat (4) @(negedge sys_clk);
            check(port_overcurrent, oc);
            check(power_switch_en, pse);
            @(posedge sys_clk);
            strap_cfg <= ~c;
            overcurrent_in_n <= 4'hf;
            repeat (6) @(negedge sys_clk);
            check(port_enable, PE[i]);
            check(gang_mode, c[0]);
            @(posedge sys_clk);
        end
        bus(1'b1, ADDR_CLEAR, 32'hff);
        bus(1'b1, ADDR_ENABLE, 32'h10);
        overcurrent_in_n <= 4'he;
        repeat (5) @(negedge sys_clk);
        check(irq, 1'b1);
        bus(1'b1, ADDR_ENABLE, 32'h0);
        repeat (2) @(negedge sys_clk);
        check(irq, 1'b0);
        bus(1'b1, ADDR_ENABLE, 32'h10);
        overcurrent_in_n <= 4'hf;
        bus(1'b0, ADDR_STATUS, 32'h0);
        check(rd, 32'h10);
        bus(1'b1, ADDR_CLEAR, 32'h10);
        repeat (2) @(negedge sys_clk);
        check(irq, 1'b0);
        bus(1'b0, ADDR_ENABLE, 32'h0);
        check(rd, 32'h10);
        bus(1'b0, 8'h20, 32'h0);
        check(rd, 32'h0);
        n = 0;
        while (mode_pin_oe !== 1'b1 && n < 1500) begin
            @(negedge sys_clk);
            n++;
        end
        check(n < 1500, 1'b1);
        bus(1'b0, ADDR_STATUS, 32'h0);
        check(rd[1], 1'b1);
        global_suspend <= 1'b1;
        repeat (3) @(negedge sys_clk);
        check(mode_pin_o, 1'b1);
        @(posedge sys_clk);
        global_suspend <= 1'b0;
        repeat (3) @(negedge sys_clk);
        check(mode_pin_o, 1'b0);
        repeat (1600) @(posedge sys_clk);
        end_sim();
    end
endmodule : hub_strap_reset_config_tb
bind hub_strap_reset_config hub_strap_monitor #(.REL_CYCLES(REL_CYCLES), .OUT_CYCLES(OUT_CYCLES)) mon (
    .sys_clk, .rst_b, .avs_read, .avs_write, .avs_waitrequest, .core_power_good, .ext_reset_n,
    .mode_pin_o, .mode_pin_oe, .global_suspend, .hub_reset, .gang_mode, .port_enable,
    .port_overcurrent, .ref_clk_src
);
`default_nettype wire
